// File: hdl/rsc_params.svh
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ****************************************
// bus map
// ****************************************
`define RSC_ADDR_W          6
`define RSC_OFF_CAUSE       6'h00
`define RSC_OFF_IRQ_STAT    6'h04
`define RSC_OFF_IRQ_CLR     6'h08
`define RSC_OFF_IRQ_EN      6'h0c
`define RSC_OFF_STATE       6'h10
`define RSC_RESP_OKAY       2'b00
`define RSC_RESP_SLVERR     2'b10

// ****************************************
// reset-cause layout and vector
// ****************************************
`define RSC_CAUSE_WDT_BIT   4
`define RSC_CAUSE_LVI_BIT   0
`define RSC_CAUSE_CLEAR     8'h00
`define RSC_VEC_ADDR_LO     16'h0000
`define RSC_VEC_ADDR_HI     16'h0001
`define RSC_IRQ_W           4

// ****************************************
// values applied at reset acknowledgment
// ****************************************
`define RSC_RV_PSW          8'h02
`define RSC_RV_PORT_LATCH   8'h00
`define RSC_RV_PORT_DIR     8'hff
`define RSC_RV_PORT_MODE    8'h00
`define RSC_RV_PULL_UP      8'h00
`define RSC_RV_CLK_CTRL     8'h02
`define RSC_RV_RING_MODE    8'h00
`define RSC_RV_TIMER_CLR    8'h00
`define RSC_RV_WDT_MODE     8'h67
`define RSC_RV_WDT_ENABLE   8'h9a
`define RSC_RV_ADC_CLR      8'h00
`define RSC_RV_UART_BUF     8'hff
`define RSC_RV_UART_MODE    8'h01
`define RSC_RV_UART_SCTL    8'h16
`define RSC_RV_UART_CLR     8'h00
`define RSC_RV_INT_MASK     8'hff
`define RSC_RV_INT_EDGE     8'h00
`define RSC_RV_LVI_CLR      8'h00

`endif

// File: hdl/rsc_pkg.sv
package rsc_pkg;

   typedef enum {
      RSC_IDLE_RUN, RSC_HOLD, RSC_SETTLE, RSC_VEC_LO, RSC_VEC_HI, RSC_VEC_END, RSC_INIT
   } rsc_state_type;

   typedef enum logic [1:0] {
      RSC_SRC_POC, RSC_SRC_PIN, RSC_SRC_WDT, RSC_SRC_LVI
   } rsc_source_type;

   // one entry per register that reset loads; undefined ones are absent
   typedef enum logic [5:0] {
      RSC_ID_PSW, RSC_ID_PORT_LATCH, RSC_ID_PORT_DIR, RSC_ID_PORT_MODE, RSC_ID_PULL_UP,
      RSC_ID_PCC, RSC_ID_PERIPHERAL_CLOCK_CONTROL, RSC_ID_LS_RING, RSC_ID_HS_RING,
      RSC_ID_WT_CNT_L, RSC_ID_WT_CNT_H, RSC_ID_WT_CCA_L, RSC_ID_WT_CCA_H,
      RSC_ID_WT_CCB_L, RSC_ID_WT_CCB_H, RSC_ID_WT_MODE, RSC_ID_WT_PRESC,
      RSC_ID_WT_CAPCTL, RSC_ID_WT_OUTCTL,
      RSC_ID_BT_CNT, RSC_ID_BT_MODE, RSC_ID_ST_CMPA, RSC_ID_ST_CMPB, RSC_ID_ST_MODE,
      RSC_ID_WDT_MODE, RSC_ID_WDT_EN, RSC_ID_ADC_MODE, RSC_ID_ADC_CHAN,
      RSC_ID_U_RXB, RSC_ID_U_TXB, RSC_ID_U_MODE, RSC_ID_U_ERR, RSC_ID_U_CLK,
      RSC_ID_U_BAUD, RSC_ID_U_SCTL, RSC_ID_ISC,
      RSC_ID_MASK0, RSC_ID_MASK1, RSC_ID_EDGE0, RSC_ID_EDGE1,
      RSC_ID_LVI_CTRL, RSC_ID_LVI_LEVEL
   } rsc_reg_id_type;

endpackage

// File: hdl/rsc_reset_state_control.sv
// What this block does
// R1 - pins high impedance, indicator bit low, during reset and settling time
// R2 - watchdog overflow reset also reinitialises the watchdog itself
// R3 - program counter loads from the two-byte vector at 0000H and 0001H
// R4 - only program counter undefined meanwhile; rest keeps state until acknowledgment
// R5 - data RAM and general registers are never initialised by reset
// R6 - processor status word becomes 02H; stack pointer left undefined
// R7 - port latches 00H, direction FFH, mode control and pull-ups 00H
// R8 - clock controls 02H, ring modes 00H, settle select left undefined
// R9 - wide timer counter and compares 0000H, its control registers 00H
// R10 - byte timer counter and mode 00H; second timer compares and mode 00H
// R11 - watchdog mode 67H and watchdog enable 9AH
// R12 - ADC results undefined; ADC mode and channel select 00H
// R13 - UART buffers and baud FFH, mode 01H, control 16H, others 00H
// R14 - interrupt masks FFH, external edge modes 00H
// R15 - low-voltage registers cleared except on a low-voltage reset
// R16 - reset-cause cleared by pin reset, power-on clear, software read
// R17 - watchdog sets cause bit 4, low-voltage sets bit 0, other held
// R18 - low-voltage reset never resets the low-voltage detector
// R19 - sources merged, synchronised on release, source recorded for retention
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`include "rsc_params.svh"

module rsc_reset_state_control
   import rsc_pkg::*;
#(
   parameter int INIT_COUNT = RSC_ID_LVI_LEVEL + 1
) (
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // reset sources (asynchronous)
   input  wire logic        ext_reset_n_in,
   input  wire logic        wdt_overflow_in,
   input  wire logic        poc_detect_in,
   input  wire logic        lvi_detect_in,
   // clock generator and memory
   input  wire logic        settle_done_in,
   input  wire logic [7:0]  vec_data_in,
   output logic             vec_rd_out,
   output logic [15:0]      vec_addr_out,
   // core and peripherals
   output logic             core_rst_out,
   output logic             wdt_rst_out,
   output logic             lvi_rst_out,
   output logic [15:0]      pc_out,
   output logic             pc_load_out,
   output logic             init_we_out,
   output logic [5:0]       init_id_out,
   output logic [7:0]       init_data_out,
   // pins
   output logic             reset_indicator_port_bit_out,
   output logic             reset_indicator_oe_out,
   output logic             port_hiz_out,
   output logic             irq_out,
   // axi4-lite slave
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ****************************************
   // reset value table
   // ****************************************
   function automatic logic [7:0] init_value(input rsc_reg_id_type id);
      unique case (id)
         RSC_ID_PSW:                      init_value = `RSC_RV_PSW;        // R6
         RSC_ID_PORT_LATCH:               init_value = `RSC_RV_PORT_LATCH; // R7
         RSC_ID_PORT_DIR:                 init_value = `RSC_RV_PORT_DIR;   // R7
         RSC_ID_PORT_MODE:                init_value = `RSC_RV_PORT_MODE;  // R7
         RSC_ID_PULL_UP:                  init_value = `RSC_RV_PULL_UP;    // R7
         RSC_ID_PCC, RSC_ID_PERIPHERAL_CLOCK_CONTROL:         init_value = `RSC_RV_CLK_CTRL;   // R8
         RSC_ID_LS_RING, RSC_ID_HS_RING:  init_value = `RSC_RV_RING_MODE;  // R8
         RSC_ID_WT_CNT_L, RSC_ID_WT_CNT_H, RSC_ID_WT_CCA_L, RSC_ID_WT_CCA_H,
         RSC_ID_WT_CCB_L, RSC_ID_WT_CCB_H, RSC_ID_WT_MODE, RSC_ID_WT_PRESC,
         RSC_ID_WT_CAPCTL, RSC_ID_WT_OUTCTL:
                                          init_value = `RSC_RV_TIMER_CLR;  // R9
         RSC_ID_BT_CNT, RSC_ID_BT_MODE, RSC_ID_ST_CMPA, RSC_ID_ST_CMPB, RSC_ID_ST_MODE:
                                          init_value = `RSC_RV_TIMER_CLR;  // R10
         RSC_ID_WDT_MODE:                 init_value = `RSC_RV_WDT_MODE;   // R11
         RSC_ID_WDT_EN:                   init_value = `RSC_RV_WDT_ENABLE; // R11
         RSC_ID_ADC_MODE, RSC_ID_ADC_CHAN: init_value = `RSC_RV_ADC_CLR;   // R12
         RSC_ID_U_RXB, RSC_ID_U_TXB, RSC_ID_U_BAUD:
                                          init_value = `RSC_RV_UART_BUF;   // R13
         RSC_ID_U_MODE:                   init_value = `RSC_RV_UART_MODE;  // R13
         RSC_ID_U_SCTL:                   init_value = `RSC_RV_UART_SCTL;  // R13
         RSC_ID_U_ERR, RSC_ID_U_CLK, RSC_ID_ISC:
                                          init_value = `RSC_RV_UART_CLR;   // R13
         RSC_ID_MASK0, RSC_ID_MASK1:      init_value = `RSC_RV_INT_MASK;   // R14
         RSC_ID_EDGE0, RSC_ID_EDGE1:      init_value = `RSC_RV_INT_EDGE;   // R14
         RSC_ID_LVI_CTRL, RSC_ID_LVI_LEVEL: init_value = `RSC_RV_LVI_CLR;  // R15
         // index runs one past the table on the last init edge
         default:                         init_value = '0;
      endcase
   endfunction

   // ****************************************
   // source synchronisers
   // ****************************************
   logic [3:0] src_raw;
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;

   assign src_raw = {lvi_detect_in, wdt_overflow_in, ~ext_reset_n_in, poc_detect_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= src_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   logic           any_src;
   rsc_source_type src_pick;
   logic           src_poc, src_pin, src_wdt, src_lvi;

   assign src_poc = sync2_r[0];
   assign src_pin = sync2_r[1];
   assign src_wdt = sync2_r[2];
   assign src_lvi = sync2_r[3];
   assign any_src = |sync2_r; // R19

   // harder sources win so that retention and the low-voltage detector reset follow the worst one
   always_comb begin
      if (src_poc)      src_pick = RSC_SRC_POC;
      else if (src_pin) src_pick = RSC_SRC_PIN;
      else if (src_wdt) src_pick = RSC_SRC_WDT;
      else              src_pick = RSC_SRC_LVI;
   end

   // ****************************************
   // sequencer
   // ****************************************
   rsc_state_type  state_r, state_nxt;
   rsc_source_type src_r;
   logic [5:0]     idx_r;
   logic [7:0]     vec_lo_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         RSC_IDLE_RUN: if (any_src) state_nxt = RSC_HOLD;
         RSC_HOLD:     if (!any_src) state_nxt = RSC_SETTLE; // R19
         RSC_SETTLE:   if (settle_done_in) state_nxt = RSC_VEC_LO;
         RSC_VEC_LO:   state_nxt = RSC_VEC_HI;
         RSC_VEC_HI:   state_nxt = RSC_VEC_END;
         RSC_VEC_END:  state_nxt = RSC_INIT;
         RSC_INIT:     if (idx_r == 6'(INIT_COUNT - 1)) state_nxt = RSC_IDLE_RUN;
      endcase
      if (any_src) state_nxt = RSC_HOLD;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) state_r <= RSC_HOLD;
      else        state_r <= state_nxt;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in)       src_r <= RSC_SRC_POC;
      else if (any_src) src_r <= src_pick; // R19
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in)                     idx_r <= 6'h00;
      else if (state_r == RSC_INIT)   idx_r <= idx_r + 6'h01;
      else                            idx_r <= 6'h00;
   end

   // ****************************************
   // resets, pins and vector fetch
   // ****************************************
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         core_rst_out                 <= 1'b1;
         wdt_rst_out                  <= 1'b1;
         lvi_rst_out                  <= 1'b1;
         reset_indicator_port_bit_out <= 1'b0;
         reset_indicator_oe_out       <= 1'b1;
         port_hiz_out                 <= 1'b1;
      end else begin
         // ram and general registers have no reset path at all // R5
         core_rst_out <= state_nxt != RSC_IDLE_RUN;
         wdt_rst_out  <= state_nxt == RSC_HOLD; // R2
         lvi_rst_out  <= state_nxt == RSC_HOLD && !(any_src && src_pick == RSC_SRC_LVI); // R18
         reset_indicator_port_bit_out <= 1'b0;
         reset_indicator_oe_out       <= state_nxt == RSC_HOLD || state_nxt == RSC_SETTLE; // R1
         port_hiz_out <= state_nxt == RSC_HOLD || state_nxt == RSC_SETTLE; // R1
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         vec_rd_out   <= 1'b0;
         vec_addr_out <= `RSC_VEC_ADDR_LO;
      end else begin
         vec_rd_out   <= state_nxt == RSC_VEC_LO || state_nxt == RSC_VEC_HI; // R3
         vec_addr_out <= (state_nxt == RSC_VEC_HI) ? `RSC_VEC_ADDR_HI : `RSC_VEC_ADDR_LO;
      end
   end

   // memory answers one cycle after the read strobe
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         vec_lo_r    <= 8'h00;
         pc_out      <= 16'h0000;
         pc_load_out <= 1'b0;
      end else begin
         if (state_r == RSC_VEC_HI) vec_lo_r <= vec_data_in; // R3
         pc_load_out <= state_r == RSC_VEC_END;
         // pc is the only thing touched before acknowledgment // R4
         if (state_r == RSC_VEC_END) pc_out <= {vec_data_in, vec_lo_r}; // R3
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         init_we_out   <= 1'b0;
         init_id_out   <= 6'h00;
         init_data_out <= 8'h00;
      end else begin
         init_id_out   <= idx_r;
         init_data_out <= init_value(rsc_reg_id_type'(idx_r));
         init_we_out   <= state_r == RSC_INIT && !(src_r == RSC_SRC_LVI &&
                          (rsc_reg_id_type'(idx_r) == RSC_ID_LVI_CTRL ||
                           rsc_reg_id_type'(idx_r) == RSC_ID_LVI_LEVEL)); // R4 R15
      end
   end

   // ****************************************
   // axi4-lite slave
   // ****************************************
   logic [7:0]          cause_r;
   logic [`RSC_IRQ_W-1:0] irq_stat_r, irq_en_r, irq_set;
   logic [5:0]          awaddr_r;
   logic                aw_have_r, w_have_r;
   logic [31:0]         wdata_r;
   logic                wr_go, rd_go, cause_rd;

   assign wr_go    = aw_have_r && w_have_r && !s_axi_bvalid;
   assign rd_go    = s_axi_arvalid && s_axi_arready;
   assign cause_rd = rd_go && s_axi_araddr == `RSC_OFF_CAUSE;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         awaddr_r      <= 6'h00;
         wdata_r       <= 32'h0000_0000;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r     <= 1'b1;
            awaddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r     <= 1'b1;
            wdata_r      <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_r == `RSC_OFF_IRQ_CLR || awaddr_r == `RSC_OFF_IRQ_EN)
                            ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RSC_RESP_OKAY;
      end else begin
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RSC_RESP_OKAY;
            unique case (s_axi_araddr)
               `RSC_OFF_CAUSE:    s_axi_rdata <= {24'h000000, cause_r};
               `RSC_OFF_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat_r};
               `RSC_OFF_IRQ_EN:   s_axi_rdata <= {28'h0000000, irq_en_r};
               `RSC_OFF_STATE:    s_axi_rdata <= {24'h000000, 2'(src_r), 3'(state_r),
                                                  core_rst_out, port_hiz_out, 1'b0};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `RSC_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ****************************************
   // reset cause and interrupts
   // ****************************************
   // an asserted reset source beats a software read in the same cycle
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) cause_r <= `RSC_CAUSE_CLEAR;
      else if (any_src && (src_poc || src_pin)) cause_r <= `RSC_CAUSE_CLEAR; // R16
      else if (any_src) begin
         if (src_wdt) cause_r[`RSC_CAUSE_WDT_BIT] <= 1'b1; // R17
         if (src_lvi) cause_r[`RSC_CAUSE_LVI_BIT] <= 1'b1; // R17
      end else if (cause_rd) cause_r <= `RSC_CAUSE_CLEAR; // R16
   end

   logic [3:0] sync2_r_d;

   assign irq_set = {src_lvi, src_wdt, src_pin, src_poc} & ~sync2_r_d;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) sync2_r_d <= 4'h0;
      else        sync2_r_d <= sync2_r;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_stat_r <= 4'h0;
         irq_en_r   <= 4'h0;
         irq_out    <= 1'b0;
      end else begin
         if (wr_go && awaddr_r == `RSC_OFF_IRQ_CLR)
            irq_stat_r <= (irq_stat_r & ~wdata_r[3:0]) | irq_set;
         else
            irq_stat_r <= irq_stat_r | irq_set;
         if (wr_go && awaddr_r == `RSC_OFF_IRQ_EN && s_axi_wstrb[0]) irq_en_r <= wdata_r[3:0];
         irq_out <= |(irq_stat_r & irq_en_r);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   chk_pins_float: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R1
      (state_r == RSC_HOLD || state_r == RSC_SETTLE) |-> port_hiz_out
      && !reset_indicator_port_bit_out && reset_indicator_oe_out)
      else $error("pins not parked during reset");
   chk_wdt_self: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R2
      src_wdt && !src_poc && !src_pin |-> ##1 wdt_rst_out)
      else $error("watchdog not reset by its own overflow");
   chk_vector_load: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R3
      state_r == RSC_VEC_HI ##1 state_r == RSC_VEC_END |->
      ##1 pc_load_out && pc_out == {$past(vec_data_in), $past(vec_data_in, 2)})
      else $error("pc not loaded from vector");
   chk_init_after: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R4
      init_we_out |-> $past(state_r) == RSC_INIT)
      else $error("initial value applied outside acknowledgment");
   chk_psw_value: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R6
      init_we_out && init_id_out == RSC_ID_PSW |-> init_data_out == `RSC_RV_PSW)
      else $error("wrong status word reset value");
   chk_wdt_values: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R11
      init_we_out && init_id_out == RSC_ID_WDT_MODE |-> init_data_out == `RSC_RV_WDT_MODE
      ##1 init_we_out && init_data_out == `RSC_RV_WDT_ENABLE)
      else $error("wrong watchdog reset values");
   chk_lvi_keep: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R15
      init_we_out && $past(src_r) == RSC_SRC_LVI |-> init_id_out != RSC_ID_LVI_CTRL
      && init_id_out != RSC_ID_LVI_LEVEL)
      else $error("low-voltage registers cleared by own reset");
   chk_cause_read: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R16
      cause_rd && !any_src |-> ##1 cause_r == `RSC_CAUSE_CLEAR)
      else $error("cause not cleared by read");
   chk_cause_wdt: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R17
      src_wdt && !src_poc && !src_pin |-> ##1 cause_r[`RSC_CAUSE_WDT_BIT]
      && cause_r[`RSC_CAUSE_LVI_BIT] == $past(cause_r[`RSC_CAUSE_LVI_BIT]) || $past(src_lvi))
      else $error("watchdog cause bit wrong");
   chk_lvi_spared: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R18
      src_lvi && !src_poc && !src_pin && !src_wdt |-> ##1 !lvi_rst_out)
      else $error("detector reset by its own reset");
   chk_release_seq: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R19
      state_r == RSC_HOLD && !any_src |-> ##1 state_r == RSC_SETTLE && core_rst_out)
      else $error("release not sequenced");

endmodule // rsc_reset_state_control

// File: sim/rsc_partner.sv
module rsc_partner
#(
   parameter logic [15:0] VEC    = 16'h1234,
   parameter int          SETTLE = 8
) (
   // clock
   input  wire logic        ref_clk_in,
   // sequencer side
   input  wire logic        hold_in,
   input  wire logic        vec_rd_in,
   input  wire logic [15:0] vec_addr_in,
   input  wire logic        pc_load_in,
   input  wire logic [15:0] pc_in,
   input  wire logic        init_we_in,
   input  wire logic [5:0]  init_id_in,
   input  wire logic [7:0]  init_data_in,
   // answers
   output logic             settle_done_out,
   output logic [7:0]       vec_data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  mem_r [42];
   logic [15:0] pc_r;
   int          cnt_r;
   initial begin
      cnt_r = 0;
      settle_done_out = 1'b0;
      vec_data_out = 8'h00;
   end
   always @(posedge ref_clk_in) begin
      cnt_r <= hold_in ? cnt_r + 1 : 0;
      settle_done_out <= hold_in && cnt_r >= SETTLE;
      // an idle bus inverts its byte every cycle, so it never shows the same byte twice running
      vec_data_out <= vec_rd_in ? (vec_addr_in[0] ? VEC[15:8] : VEC[7:0]) : ~vec_data_out;
      if (pc_load_in) pc_r <= pc_in;
      // marker value shows which entries a reset left alone
      for (int i = 0; i < 42; i++) if (hold_in) mem_r[i] <= 8'haa;
      if (init_we_in) mem_r[init_id_in] <= init_data_in;
   end
endmodule // rsc_partner

// File: sim/tb.sv
`include "rsc_params.svh"
`define RSC_CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // signals
   // ****************************************
   logic ref_clk_in = 0, rst_in = 1, settle_done_in;
   // source requests by index: 0 power-on, 1 pin, 2 watchdog, 3 low-voltage
   logic [3:0] src = 4'h0;
   wire logic ext_reset_n_in = ~src[1], wdt_overflow_in = src[2];
   wire logic poc_detect_in = src[0], lvi_detect_in = src[3];
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [7:0] vec_data_in, init_data_out;
   logic [5:0] init_id_out;
   logic [15:0] vec_addr_out, pc_out;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata;
   logic vec_rd_out, core_rst_out, wdt_rst_out, lvi_rst_out, pc_load_out, init_we_out, irq_out;
   logic reset_indicator_port_bit_out, reset_indicator_oe_out, port_hiz_out;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, seen_w, seen_l;
   int miscompares = 0, checks_done = 0;
   localparam logic [7:0] EXP [42] = '{8'h02, 8'h0, 8'hff, 8'h0, 8'h0, 8'h02, 8'h02, 8'h0,
      8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0,
      8'h0, 8'h0, 8'h67, 8'h9a, 8'h0, 8'h0, 8'hff, 8'hff, 8'h01, 8'h0, 8'h0, 8'hff, 8'h16,
      8'h0, 8'hff, 8'hff, 8'h0, 8'h0, 8'h0, 8'h0};
   rsc_reset_state_control DUT (.*);
   rsc_partner P (.ref_clk_in, .hold_in(reset_indicator_oe_out), .vec_rd_in(vec_rd_out),
      .vec_addr_in(vec_addr_out), .pc_load_in(pc_load_out), .pc_in(pc_out),
      .init_we_in(init_we_out), .init_id_in(init_id_out), .init_data_in(init_data_out),
      .settle_done_out(settle_done_in), .vec_data_out(vec_data_in));
   initial forever #25 ref_clk_in = ~ref_clk_in;
   // ****************************************
   // bus and sequence tasks
   // ****************************************
   task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge ref_clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk_in);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && s_axi_awready !== 1'b1) || (s_axi_wvalid && s_axi_wready !== 1'b1));
      do @(posedge ref_clk_in); while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge ref_clk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge ref_clk_in); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk_in); while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic wait_run;
      do begin
         @(posedge ref_clk_in);
         seen_w |= wdt_rst_out;
         seen_l |= lvi_rst_out;
      end while (core_rst_out !== 1'b0);
      // the last table entry lands in the partner on this edge
      @(negedge ref_clk_in);
      `RSC_CHK({port_hiz_out, P.pc_r}, {1'b0, 16'h1234})
   endtask
   // the source is held long enough to pass the synchroniser and reach hold
   task automatic rst_by(input int k);
      @(posedge ref_clk_in);
      src[k] <= 1'b1;
      seen_w = 0;
      seen_l = 0;
      repeat (5) @(posedge ref_clk_in);
      `RSC_CHK({port_hiz_out, reset_indicator_oe_out, reset_indicator_port_bit_out}, 3'b110)
      src[k] <= 1'b0;
      wait_run();
   endtask
   task automatic check_tab(input logic low_voltage_detector);
      for (int i = 0; i < 42; i++)
         `RSC_CHK(P.mem_r[i], (low_voltage_detector && i >= 40) ? 8'haa : EXP[i])
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (5000) @(posedge ref_clk_in);
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      wait_run();
      check_tab(1'b0);
      rd(`RSC_OFF_CAUSE, d, r);
      `RSC_CHK(d, 32'h0)
      rst_by(2);
      `RSC_CHK({seen_w, seen_l}, 2'b11)
      check_tab(1'b0);
      rst_by(3);
      `RSC_CHK({seen_w, seen_l}, 2'b10)
      check_tab(1'b1);
      rd(`RSC_OFF_CAUSE, d, r);
      `RSC_CHK(d, 32'h11)
      rd(`RSC_OFF_CAUSE, d, r);
      `RSC_CHK(d, 32'h0)
      rst_by(2);
      rst_by(1);
      rd(`RSC_OFF_CAUSE, d, r);
      `RSC_CHK(d, 32'h0)
      rst_by(2);
      rst_by(0);
      rd(`RSC_OFF_CAUSE, d, r);
      `RSC_CHK(d, 32'h0)
      rd(`RSC_OFF_IRQ_STAT, d, r);
      `RSC_CHK(d, 32'hf)
      wr(`RSC_OFF_IRQ_EN, 32'h4, r);
      repeat (2) @(posedge ref_clk_in);
      `RSC_CHK(irq_out, 1'b1)
      wr(`RSC_OFF_IRQ_CLR, 32'h4, r);
      repeat (2) @(posedge ref_clk_in);
      `RSC_CHK({irq_out, r}, {1'b0, `RSC_RESP_OKAY})
      rd(`RSC_OFF_IRQ_STAT, d, r);
      `RSC_CHK(d, 32'hb)
      wr(`RSC_OFF_CAUSE, 32'h0, r);
      `RSC_CHK(r, `RSC_RESP_SLVERR)
      rd(6'h14, d, r);
      `RSC_CHK({r, d}, {`RSC_RESP_SLVERR, 32'h0})
      finish_test();
   end
endmodule // tb
